/* File: bench/sisp_board.sv */
`timescale 1ns/1ps
module sisp_board
    import sisp_pkg::*;
(
    input sisp_pin_t dup_pin, // Duplex pin drive from the device
    input sisp_pin_t ca_pin, // Collision/activity pin drive from the device
    input wire logic dup_strap, // Strap resistor level, duplex pin
    input wire logic ca_strap, // Strap resistor level, collision/activity pin
    input wire logic pd_drive, // Board actively drives power-down pin
    input wire logic pd_level, // Level driven on power-down pin
    output logic dup_level, // Duplex wire level
    output logic ca_level, // Collision/activity wire level
    output logic pd_n, // Power-down wire level
    output logic dup_lit, // Duplex lamp lit
    output logic ca_lit // Collision/activity lamp lit
);
    // Strap resistor wins only while the device leaves the pin undriven
    assign dup_level = dup_pin.oe ? dup_pin.o : dup_strap;
    assign ca_level = ca_pin.oe ? ca_pin.o : ca_strap;
    assign pd_n = pd_drive ? pd_level : 1'b1;
    assign dup_lit = dup_pin.oe & ~dup_pin.o;
    assign ca_lit = ca_pin.oe & ~ca_pin.o;
endmodule // sisp_board

/* File: bench/sisp_strap_ind_tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module sisp_strap_ind_tb_top
    import sisp_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, dup_i, ca_i, pd_n, dup_lit, ca_lit, ctrl_dup, ctrl_aneg, pwr_down;
    logic dup_strap = 1'b1, ca_strap = 1'b0, pd_drive = 1'b0, pd_level = 1'b1;
    sisp_pin_t dup_pin, ca_pin;
    sisp_link_t link = '0, l;
    logic [1:0] m;
    logic [32:0] exp_q[$];
    logic [32:0] exp_w;
    int n_fail = 0, total_checks = 0, c_dup, c_ca;
    integer seed = 32'h349b;

    always #25 clk = ~clk;

    sisp_strap_ind #(.BLINK_CYC(4)) dut (.CLK_SYS(clk), .RESET(reset), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .DUPLEX_IND_I(dup_i),
        .DUPLEX_IND(dup_pin), .CA_IND_I(ca_i), .CA_IND(ca_pin), .POWER_DOWN_N(pd_n),
        .LINK(link), .CTRL_DUPLEX(ctrl_dup), .CTRL_AUTONEG(ctrl_aneg), .POWER_DOWN(pwr_down));

    sisp_board board (.dup_pin(dup_pin), .ca_pin(ca_pin), .dup_strap(dup_strap),
        .ca_strap(ca_strap), .pd_drive(pd_drive), .pd_level(pd_level), .dup_level(dup_i),
        .ca_level(ca_i), .pd_n(pd_n), .dup_lit(dup_lit), .ca_lit(ca_lit));

    // ****************************************
    // Read monitor and bus tasks
    // ****************************************
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, prdata, 32'h0);
            end else begin
                exp_w = exp_q.pop_front();
                `CHK({pslverr, prdata}, exp_w)
            end
        end
    end

    task finish_test;
        $display("checks=%0d fails=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                n_fail++;
                finish_test();
            end
            @(posedge clk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [31:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, $random(seed), 4'h0);
    endtask

    task do_reset(input int cyc, input logic ds, input logic cs);
        @(posedge clk);
        reset <= 1'b1;
        dup_strap <= ds;
        ca_strap <= cs;
        repeat (cyc) @(posedge clk);
        `CHK({dup_pin.oe, ca_pin.oe}, 2'b00)
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK({dup_pin.oe, ca_pin.oe}, 2'b11)
        `CHK({ctrl_aneg, ctrl_dup}, {cs, ds})
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        do_reset(16, 1'b1, 1'b0);
        rd(SISP_ADDR_CTRL, {1'b0, 32'h100});
        rd(SISP_ADDR_STAT, {1'b0, 32'h4});
        do_reset(999, 1'b1, 1'b1);
        rd(SISP_ADDR_STAT, {1'b0, 32'hc});
        do_reset(1000, 1'b0, 1'b1);
        rd(SISP_ADDR_CTRL, {1'b0, 32'h1000});
        rd(SISP_ADDR_STAT, {1'b0, 32'ha});
        // Writes without the control byte strobe, and to status, change nothing
        apb(1'b1, SISP_ADDR_CTRL, 32'h100, 4'h1);
        apb(1'b1, SISP_ADDR_STAT, 32'hffffffff, 4'hf);
        rd(SISP_ADDR_CTRL, {1'b0, 32'h1000});
        rd(SISP_ADDR_STAT, {1'b0, 32'ha});
        rd(32'h40, {1'b1, 32'h0});
        apb(1'b1, SISP_ADDR_CTRL, 32'h100, 4'h2);
        rd(SISP_ADDR_CTRL, {1'b0, 32'h100});
        `CHK({ctrl_aneg, ctrl_dup}, 2'b01)
        rd(SISP_ADDR_INDMODE, {1'b0, 32'h0});
        for (int i = 0; i < 16; i++) begin
            m = i[1:0];
            r = $random(seed);
            l = r[2:0];
            l.activity = 1'b0;
            if (m == 2'h1)
                l.collision = 1'b0;
            apb(1'b1, SISP_ADDR_INDMODE, {30'h0, m}, 4'h1);
            link <= l;
            rd(SISP_ADDR_INDMODE, {1'b0, 30'h0, m});
            repeat (2) @(posedge clk);
            `CHK(dup_lit, l.full_duplex)
            `CHK(ca_lit, (m == 2'h0 || m == 2'h3) & l.collision)
        end
        // Toggling modes: the collision/activity lamp must be both lit and dark over a few periods, the duplex lamp in mode 1 only
        for (int k = 1; k < 3; k++) begin
            apb(1'b1, SISP_ADDR_INDMODE, k, 4'h1);
            link <= '{full_duplex: 1'b1, collision: 1'b1, activity: 1'b1};
            c_dup = 0;
            c_ca = 0;
            repeat (2) @(posedge clk);
            repeat (16) begin
                @(posedge clk);
                c_dup += dup_lit;
                c_ca += ca_lit;
            end
            `CHK(c_ca > 0 && c_ca < 16, 1'b1)
            `CHK(c_dup > 0 && c_dup < 16, k == 1)
        end
        apb(1'b1, SISP_ADDR_INDMODE, 32'h0, 4'h1);
        link <= '{full_duplex: 1'b1, collision: 1'b1, activity: 1'b0};
        pd_drive <= 1'b1;
        pd_level <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK({pwr_down, dup_lit, ca_lit}, 3'b100)
        rd(SISP_ADDR_STAT, {1'b0, 32'hb});
        pd_drive <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK({pwr_down, dup_lit, ca_lit}, 3'b011)
        finish_test();
    end
endmodule // sisp_strap_ind_tb_top

/* File: verilog/sisp_blink.sv */
`timescale 1ns/1ps
module sisp_blink
    import sisp_pkg::*;
#(
    parameter int unsigned HALF_CYC = SISP_BLINK_CYC
) (
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset, high
    output logic phase // Toggle phase for blinking indicators
);
    typedef struct packed {
        logic [31:0] cnt;
        logic phase;
    } sisp_blink_st_t;

    sisp_blink_st_t st_r;
    sisp_blink_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (reset) begin
            st_nxt = '0;
        end else if (st_r.cnt >= 32'(HALF_CYC - 1)) begin
            st_nxt.cnt = '0;
            st_nxt.phase = ~st_r.phase;
        end else begin
            st_nxt.cnt = st_r.cnt + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    assign phase = st_r.phase;

endmodule // sisp_blink

/* File: verilog/sisp_ind_sel.sv */
`timescale 1ns/1ps
module sisp_ind_sel
    import sisp_pkg::*;
(
    input sisp_mode_t mode, // Indicator mode
    input sisp_link_t link, // Link conditions
    input wire logic blink, // Blink phase
    input wire logic pd, // Power-down active
    output logic dup_on, // Duplex indicator lit
    output logic ca_on // Collision/activity indicator lit
);
    always_comb begin
        dup_on = 1'b0;
        ca_on = 1'b0;
        case (mode)
            SISP_MODE_FDX_ACT: begin
                dup_on = link.collision ? blink : link.full_duplex;
                ca_on = link.activity & blink;
            end
            SISP_MODE_DUP_ACT: begin
                dup_on = link.full_duplex;
                ca_on = link.activity & blink;
            end
            default: begin
                // Reserved code behaves like the default mode
                dup_on = link.full_duplex;
                ca_on = link.collision;
            end
        endcase
        if (pd) begin
            dup_on = 1'b0;
            ca_on = 1'b0;
        end
    end

endmodule // sisp_ind_sel

/* File: verilog/sisp_pkg.sv */
package sisp_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned SISP_CLK_HZ = 20000000;
    localparam int unsigned SISP_RST_MIN_US = 50;
    localparam int unsigned SISP_RST_MIN_CYC =
        (SISP_RST_MIN_US * SISP_CLK_HZ + 999999) / 1000000;
    localparam int unsigned SISP_BLINK_MS = 100;
    localparam int unsigned SISP_BLINK_CYC = SISP_BLINK_MS * (SISP_CLK_HZ / 1000);
    localparam int unsigned SISP_RST_CNT_W = 10;

    // ************************************************************
    // Register map (index, byte address is four times the index)
    // ************************************************************
    localparam logic [7:0] SISP_IDX_CTRL = 8'h00;
    localparam logic [7:0] SISP_IDX_INDMODE = 8'h1e;
    localparam logic [7:0] SISP_IDX_STAT = 8'h1f;
    localparam logic [31:0] SISP_ADDR_CTRL = {22'h0, SISP_IDX_CTRL, 2'b00};
    localparam logic [31:0] SISP_ADDR_INDMODE = {22'h0, SISP_IDX_INDMODE, 2'b00};
    localparam logic [31:0] SISP_ADDR_STAT = {22'h0, SISP_IDX_STAT, 2'b00};

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int unsigned SISP_CTRL_DUPLEX_BIT = 8;
    localparam int unsigned SISP_CTRL_ANEG_BIT = 12;
    localparam int unsigned SISP_MODE_LSB = 0;
    localparam int unsigned SISP_STAT_PD_BIT = 0;
    localparam int unsigned SISP_STAT_STRAP_OK_BIT = 1;
    localparam int unsigned SISP_STAT_DUP_STRAP_BIT = 2;
    localparam int unsigned SISP_STAT_ANEG_STRAP_BIT = 3;

    typedef enum logic [1:0] {
        SISP_MODE_DUP_COL = 2'h0,
        SISP_MODE_FDX_ACT = 2'h1,
        SISP_MODE_DUP_ACT = 2'h2,
        SISP_MODE_RSVD = 2'h3
    } sisp_mode_t;

    localparam sisp_mode_t SISP_MODE_RST = SISP_MODE_DUP_COL;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic o;
        logic oe;
    } sisp_pin_t;

    typedef struct packed {
        logic full_duplex;
        logic collision;
        logic activity;
    } sisp_link_t;

    typedef struct packed {
        logic strap_done;
        logic duplex;
        logic autoneg;
        logic dup_strap;
        logic aneg_strap;
        logic strap_ok;
        logic [SISP_RST_CNT_W-1:0] rst_cnt;
        sisp_mode_t mode;
        logic pd;
        logic dup_o;
        logic ca_o;
        logic [31:0] prdata;
    } sisp_state_t;

endpackage

/* File: verilog/sisp_strap_ind.sv */
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
// How it works
// - While reset is held the duplex pin is read and its level lands in control bit 8.
// - After reset the duplex pin is an output, driven low to light and high to darken.
// - While reset is held the collision/activity pin is read into control bit 12.
// - After reset the collision/activity pin is an active-low output set by the mode register.
// - A low power-down input enters power-down and a high one runs normally.
// - The dual-use pins are inputs from the second cycle of reset through the first cycle after it, and outputs at all other times.
module sisp_strap_ind
    import sisp_pkg::*;
#(
    parameter int unsigned BLINK_CYC = SISP_BLINK_CYC
) (
    input wire logic CLK_SYS, // System clock, 20 MHz
    input wire logic RESET, // Synchronous reset, high
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB enable
    input wire logic PWRITE, // APB direction
    input wire logic [31:0] PADDR, // APB byte address
    input wire logic [31:0] PWDATA, // APB write data
    input wire logic [3:0] PSTRB, // APB byte strobes
    output logic [31:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // APB error on unmapped address
    input wire logic DUPLEX_IND_I, // Duplex pin level
    output sisp_pin_t DUPLEX_IND, // Duplex pin drive and enable
    input wire logic CA_IND_I, // Collision/activity pin level
    output sisp_pin_t CA_IND, // Collision/activity pin drive and enable
    input wire logic POWER_DOWN_N, // Power-down request, low active
    input sisp_link_t LINK, // Link conditions from the core
    output logic CTRL_DUPLEX, // Selected full duplex
    output logic CTRL_AUTONEG, // Auto-negotiation enabled
    output logic POWER_DOWN // Power-down state
);

    // ************************************************************
    // Address decode
    // ************************************************************
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_CTRL = 2'h1;
    localparam logic [1:0] SEL_MODE = 2'h2;
    localparam logic [1:0] SEL_STAT = 2'h3;

    function automatic logic [1:0] decode(input logic [31:0] addr);
        logic [1:0] sel;
        sel = SEL_NONE;
        if (addr == SISP_ADDR_CTRL) begin
            sel = SEL_CTRL;
        end else if (addr == SISP_ADDR_INDMODE) begin
            sel = SEL_MODE;
        end else if (addr == SISP_ADDR_STAT) begin
            sel = SEL_STAT;
        end
        return sel;
    endfunction

    sisp_state_t st_r;
    sisp_state_t st_nxt;
    logic blink;
    logic dup_on;
    logic ca_on;
    logic pd_now;
    logic [1:0] sel;
    logic wr_en;
    logic rd_setup;
    logic [31:0] rd_word;

    assign pd_now = ~POWER_DOWN_N;
    assign sel = decode(PADDR);
    assign wr_en = PSEL & PENABLE & PWRITE & (sel != SEL_NONE);
    assign rd_setup = PSEL & ~PENABLE & ~PWRITE;

    // ************************************************************
    // Blink source and indicator selection
    // ************************************************************
    sisp_blink #(
        .HALF_CYC(BLINK_CYC)
    ) u_blink (
        .clk(CLK_SYS),
        .reset(RESET),
        .phase(blink)
    );

    sisp_ind_sel u_sel (
        .mode(st_r.mode),
        .link(LINK),
        .blink(blink),
        .pd(pd_now),
        .dup_on(dup_on),
        .ca_on(ca_on)
    );

    // ************************************************************
    // Read word assembly
    // ************************************************************
    always_comb begin
        rd_word = '0;
        if (sel == SEL_CTRL) begin
            rd_word[SISP_CTRL_DUPLEX_BIT] = st_r.duplex;
            rd_word[SISP_CTRL_ANEG_BIT] = st_r.autoneg;
        end else if (sel == SEL_MODE) begin
            rd_word[SISP_MODE_LSB +: 2] = st_r.mode;
        end else if (sel == SEL_STAT) begin
            rd_word[SISP_STAT_PD_BIT] = st_r.pd;
            rd_word[SISP_STAT_STRAP_OK_BIT] = st_r.strap_ok;
            rd_word[SISP_STAT_DUP_STRAP_BIT] = st_r.dup_strap;
            rd_word[SISP_STAT_ANEG_STRAP_BIT] = st_r.aneg_strap;
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        if (RESET) begin
            st_nxt = '0;
            st_nxt.mode = SISP_MODE_RST;
            st_nxt.dup_o = 1'b1;
            st_nxt.ca_o = 1'b1;
            // Pins float as inputs at their strap resistor levels; the last reset cycle wins
            st_nxt.duplex = DUPLEX_IND_I;
            st_nxt.dup_strap = DUPLEX_IND_I;
            st_nxt.autoneg = CA_IND_I;
            st_nxt.aneg_strap = CA_IND_I;
            // First reset edge after running, or after power-up, restarts the count
            if (!st_r.strap_done) begin
                if (st_r.rst_cnt != {SISP_RST_CNT_W{1'b1}}) begin
                    st_nxt.rst_cnt = st_r.rst_cnt + 1'b1;
                end else begin
                    st_nxt.rst_cnt = st_r.rst_cnt;
                end
            end else begin
                st_nxt.rst_cnt = SISP_RST_CNT_W'(1);
            end
        end else begin
            st_nxt.strap_done = 1'b1;
            if (!st_r.strap_done) begin
                // Flags whether reset was long enough for a clean strap
                st_nxt.strap_ok = (st_r.rst_cnt >= SISP_RST_CNT_W'(SISP_RST_MIN_CYC));
                st_nxt.rst_cnt = '0;
            end
            st_nxt.pd = pd_now;
            st_nxt.dup_o = ~dup_on;
            st_nxt.ca_o = ~ca_on;
            if (rd_setup) begin
                st_nxt.prdata = rd_word;
            end
            if (wr_en && sel == SEL_CTRL && PSTRB[1]) begin
                st_nxt.duplex = PWDATA[SISP_CTRL_DUPLEX_BIT];
                st_nxt.autoneg = PWDATA[SISP_CTRL_ANEG_BIT];
            end
            if (wr_en && sel == SEL_MODE && PSTRB[0]) begin
                st_nxt.mode = sisp_mode_t'(PWDATA[SISP_MODE_LSB +: 2]);
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        st_r <= st_nxt;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & (sel == SEL_NONE);
    assign PRDATA = st_r.prdata;
    assign DUPLEX_IND.o = st_r.dup_o;
    assign DUPLEX_IND.oe = st_r.strap_done;
    assign CA_IND.o = st_r.ca_o;
    assign CA_IND.oe = st_r.strap_done;
    assign CTRL_DUPLEX = st_r.duplex;
    assign CTRL_AUTONEG = st_r.autoneg;
    assign POWER_DOWN = st_r.pd;

    // ************************************************************
    // Checks
    // ************************************************************
    a_duplex_strap: assert property (@(posedge CLK_SYS)
        $fell(RESET) |-> (CTRL_DUPLEX == $past(DUPLEX_IND_I)))
        else $error("duplex strap not latched");

    a_autoneg_strap: assert property (@(posedge CLK_SYS)
        $fell(RESET) |-> (CTRL_AUTONEG == $past(CA_IND_I)))
        else $error("auto-negotiation strap not latched");

    a_pin_input_reset: assert property (@(posedge CLK_SYS)
        $past(RESET) |-> (!DUPLEX_IND.oe && !CA_IND.oe))
        else $error("indicator pin driven during reset");

    a_pin_output_run: assert property (@(posedge CLK_SYS)
        (!RESET && !$past(RESET) && !$past(RESET, 2)) |-> (DUPLEX_IND.oe && CA_IND.oe))
        else $error("indicator pin not driven after reset");

    a_pd_follows: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (!POWER_DOWN_N ##1 !RESET) |-> POWER_DOWN)
        else $error("power-down not entered");

    a_pd_dark: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (POWER_DOWN && $past(!RESET)) |-> (DUPLEX_IND.o && CA_IND.o))
        else $error("indicator lit in power-down");

    a_mode0_duplex: assert property (@(posedge CLK_SYS) disable iff (RESET)
        ($past(!RESET) && $past(st_r.mode) == SISP_MODE_DUP_COL && $past(POWER_DOWN_N))
        |-> (DUPLEX_IND.o == !$past(LINK.full_duplex)))
        else $error("duplex indicator wrong in mode 00");

    a_mode0_coll: assert property (@(posedge CLK_SYS) disable iff (RESET)
        ($past(!RESET) && $past(st_r.mode) == SISP_MODE_DUP_COL && $past(POWER_DOWN_N))
        |-> (CA_IND.o == !$past(LINK.collision)))
        else $error("collision indicator wrong in mode 00");

    a_act_idle_dark: assert property (@(posedge CLK_SYS) disable iff (RESET)
        ($past(!RESET) && $past(st_r.mode) == SISP_MODE_DUP_ACT && !$past(LINK.activity))
        |-> CA_IND.o)
        else $error("activity indicator lit without activity");

    a_mode_write: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (PSEL && PENABLE && PWRITE && PADDR == SISP_ADDR_INDMODE && PSTRB[0])
        |=> (st_r.mode == $past(PWDATA[1:0])))
        else $error("indicator mode not written");

    a_strap_ok: assert property (@(posedge CLK_SYS)
        ($fell(RESET) ##1 1'b1) |-> (st_r.strap_ok ==
            ($past(st_r.rst_cnt) >= SISP_RST_CNT_W'(SISP_RST_MIN_CYC))))
        else $error("reset length flag wrong");

    a_mode1_dup_blink: assert property (@(posedge CLK_SYS) disable iff (RESET)
        ($past(!RESET) && $past(st_r.mode) == SISP_MODE_FDX_ACT && $past(POWER_DOWN_N)
        && $past(LINK.collision)) |-> (DUPLEX_IND.o == !$past(blink)))
        else $error("duplex indicator not toggling on collision");

    a_act_blink: assert property (@(posedge CLK_SYS) disable iff (RESET)
        ($past(!RESET) && $past(st_r.mode) != SISP_MODE_DUP_COL
        && $past(st_r.mode) != SISP_MODE_RSVD && $past(POWER_DOWN_N)
        && $past(LINK.activity)) |-> (CA_IND.o == !$past(blink)))
        else $error("activity indicator not toggling");

    a_mode2_duplex: assert property (@(posedge CLK_SYS) disable iff (RESET)
        ($past(!RESET) && $past(st_r.mode) == SISP_MODE_DUP_ACT && $past(POWER_DOWN_N))
        |-> (DUPLEX_IND.o == !$past(LINK.full_duplex)))
        else $error("duplex indicator wrong in mode 10");

    a_ctrl_stable: assert property (@(posedge CLK_SYS) disable iff (RESET)
        !(PSEL && PENABLE && PWRITE && PADDR == SISP_ADDR_CTRL && PSTRB[1])
        |=> ($stable(CTRL_DUPLEX) && $stable(CTRL_AUTONEG)))
        else $error("control bits changed without a write");

    a_unmapped_err: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (PSEL && PENABLE && decode(PADDR) == SEL_NONE) |-> PSLVERR)
        else $error("unmapped access not flagged");

endmodule // sisp_strap_ind
